/* File: src/gpio_ports_misc_control.sv */
// six gpio ports, misc control one, interrupt status and avalon slave
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "gpio_ports_misc_control_regs.svh"
// How it works
// - value latch writes are always stored, also while the pin is input
// - reading the value of an input pin returns the pin's present level
// - direction bit 0 makes its pin input, 1 makes it output
// - config bit 1 on an input of ports A and D enables interrupt
// - output config 0 gives open drain, 1 gives push-pull
// - ports B and F have no config register; direction alone sets mode
// - all port registers reset to zero, so every pin starts as input
// - port registers decode consecutively, index 5 unused, up to F direction
// - group A sensitivity: fall+low, rise, fall, both edges
// - group D sensitivity uses the same four encodings
// - sensitivity fields change only while both cpu mask bits are one
// - clock pin output enable bit routes the cpu clock to its pin
// - divide enable zero gives default cpu clock of 3 or 6 MHz
// - divide select codes pick cpu clock from oscillator or pll
// - cpu clock divide never changes the transfer coprocessor clock
module gpio_ports_misc_control #(
	parameter int NUM_PORTS = 6,
	parameter int PORT_WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire gpio_ports_misc_control_pkg::avalon_req_t av_req,
	output logic [31:0] av_readdata,
	output logic av_waitrequest,
	input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_in,
	output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_out,
	output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_oe_n,
	input wire logic irq_mask_hi,
	input wire logic irq_mask_lo,
	input wire logic usb_mode,
	output logic clk_pin_out_enable,
	output logic [7:0] cpu_clk_div,
	output logic [7:0] coproc_clk_div,
	output logic irq
);
	localparam int PA = 0;
	localparam int PB = 1;
	localparam int PC = 2;
	localparam int PD = 3;
	localparam int PE = 4;
	localparam int PF = 5;

	if (NUM_PORTS != 6 || PORT_WIDTH != 8) begin : g_size_check
		$error("gpio block supports exactly six 8-bit ports");
	end

	function automatic gpio_ports_misc_control_pkg::reg_sel_t decode(input logic [5:0] idx);
		gpio_ports_misc_control_pkg::reg_sel_t s;
		s = '0;
		s.hit = 1'b1;
		case (idx)
			`IDX_PORT_A_VALUE: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_VALUE), 3'(PA)};
			`IDX_PORT_A_DIRECTION: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_DIR), 3'(PA)};
			`IDX_PORT_A_PAD_CONFIG: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_CFG), 3'(PA)};
			`IDX_PORT_B_VALUE: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_VALUE), 3'(PB)};
			`IDX_PORT_B_DIRECTION: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_DIR), 3'(PB)};
			`IDX_PORT_C_VALUE: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_VALUE), 3'(PC)};
			`IDX_PORT_C_DIRECTION: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_DIR), 3'(PC)};
			`IDX_PORT_C_PAD_CONFIG: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_CFG), 3'(PC)};
			`IDX_PORT_D_VALUE: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_VALUE), 3'(PD)};
			`IDX_PORT_D_DIRECTION: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_DIR), 3'(PD)};
			`IDX_PORT_D_PAD_CONFIG: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_CFG), 3'(PD)};
			`IDX_PORT_E_VALUE: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_VALUE), 3'(PE)};
			`IDX_PORT_E_DIRECTION: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_DIR), 3'(PE)};
			`IDX_PORT_E_PAD_CONFIG: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_CFG), 3'(PE)};
			`IDX_PORT_F_VALUE: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_VALUE), 3'(PF)};
			`IDX_PORT_F_DIRECTION: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_DIR), 3'(PF)};
			`IDX_MISC_CONTROL_ONE: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_MISC), 3'h0};
			`IDX_IRQ_STATUS: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_MISC), 3'h1};
			`IDX_IRQ_MASK: s = {1'b1, 2'(gpio_ports_misc_control_pkg::KIND_MISC), 3'h2};
			default: s = '0;
		endcase
		return s;
	endfunction

	// one event detector serves both interrupt groups
	function automatic logic ext_event(input logic [1:0] sel, input logic [7:0] rise,
		input logic [7:0] fall, input logic [7:0] low, input logic [7:0] en);
		case (sel)
			`SENS_FALL_LOW: return |((fall | low) & en);
			`SENS_RISE: return |(rise & en);
			`SENS_FALL: return |(fall & en);
			default: return |((rise | fall) & en);
		endcase
	endfunction

	function automatic logic [7:0] div_of(input logic usb, input logic en, input logic [1:0] sel);
		logic [15:0] src;
		logic [15:0] f;
		src = usb ? `PLL_KHZ : `OSC_KHZ;
		f = usb ? `PLL_DEFAULT_KHZ : `OSC_DEFAULT_KHZ;
		if (en) begin
			case (sel)
				2'h0: f = usb ? `PLL_SEL0_KHZ : `OSC_SEL0_KHZ;
				2'h1: f = usb ? `PLL_SEL1_KHZ : `OSC_SEL1_KHZ;
				2'h2: f = usb ? `PLL_SEL2_KHZ : `OSC_SEL2_KHZ;
				default: f = usb ? `PLL_SEL3_KHZ : `OSC_SEL3_KHZ;
			endcase
		end
		return 8'(src / f);
	endfunction

	gpio_ports_misc_control_pkg::bus_state_t bus_q;
	logic [31:0] readdata_q;
	logic waitrequest_q;
	logic [NUM_PORTS-1:0][7:0] value_q;
	logic [NUM_PORTS-1:0][7:0] dir_q;
	logic [NUM_PORTS-1:0][7:0] cfg_q;
	logic [NUM_PORTS-1:0][7:0] sync1_q;
	logic [NUM_PORTS-1:0][7:0] sync2_q;
	logic [NUM_PORTS-1:0][7:0] prev_q;
	logic [NUM_PORTS-1:0][7:0] pin_out_q;
	logic [NUM_PORTS-1:0][7:0] pin_oe_n_q;
	logic [7:0] misc_q;
	logic [1:0] status_q;
	logic [1:0] status_d;
	logic [1:0] mask_q;
	logic irq_q;
	logic [7:0] cpu_div_q;
	logic [7:0] coproc_div_q;

	wire gpio_ports_misc_control_pkg::reg_sel_t sel = decode(av_req.address[7:2]);
	wire req = av_req.read || av_req.write;
	wire wr_fire = (bus_q == gpio_ports_misc_control_pkg::BUS_DONE) && av_req.write &&
		av_req.byteenable[0] && sel.hit;
	wire [7:0] wdata = av_req.writedata[7:0];
	wire is_value = sel.kind == 2'(gpio_ports_misc_control_pkg::KIND_VALUE);
	wire is_dir = sel.kind == 2'(gpio_ports_misc_control_pkg::KIND_DIR);
	wire is_cfg = sel.kind == 2'(gpio_ports_misc_control_pkg::KIND_CFG);
	wire is_misc = sel.kind == 2'(gpio_ports_misc_control_pkg::KIND_MISC);
	wire wr_misc = wr_fire && is_misc && sel.port == 3'h0;
	wire wr_status = wr_fire && is_misc && sel.port == 3'h1;
	wire wr_mask = wr_fire && is_misc && sel.port == 3'h2;
	wire mask_level3 = irq_mask_hi && irq_mask_lo;
	wire [7:0] sens_keep = {2'h3, 1'b0, 2'h3, 3'h0};
	wire [7:0] misc_d = mask_level3 ? wdata : ((misc_q & sens_keep) | (wdata & ~sens_keep));
	wire [7:0] rise_a = sync2_q[PA] & ~prev_q[PA];
	wire [7:0] fall_a = ~sync2_q[PA] & prev_q[PA];
	wire [7:0] rise_d = sync2_q[PD] & ~prev_q[PD];
	wire [7:0] fall_d = ~sync2_q[PD] & prev_q[PD];
	wire [7:0] en_a = ~dir_q[PA] & cfg_q[PA];
	wire [7:0] en_d = ~dir_q[PD] & cfg_q[PD];
	wire ev_a = ext_event(misc_q[`MISC_EDGE_SEL_A_HI:`MISC_EDGE_SEL_A_LO], rise_a, fall_a,
		~sync2_q[PA], en_a);
	wire ev_d = ext_event(misc_q[`MISC_EDGE_SEL_D_HI:`MISC_EDGE_SEL_D_LO], rise_d, fall_d,
		~sync2_q[PD], en_d);
	wire [1:0] events = {ev_d, ev_a};
	wire [1:0] status_clr = wr_status ? wdata[1:0] : 2'h0;
	wire [7:0] port_rd = is_value ? ((value_q[sel.port] & dir_q[sel.port]) |
		(sync2_q[sel.port] & ~dir_q[sel.port])) :
		is_dir ? dir_q[sel.port] : is_cfg ? cfg_q[sel.port] : 8'h00;
	wire [7:0] misc_rd = sel.port == 3'h0 ? misc_q : sel.port == 3'h1 ? {6'h00, status_q} :
		{6'h00, mask_q};
	wire [7:0] rd_byte = !sel.hit ? 8'h00 : is_misc ? misc_rd : port_rd;

	// ports without config behave as push-pull outputs
	logic [NUM_PORTS-1:0][7:0] oe_n_d;
	always_comb begin
		oe_n_d = '1;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (p == PB || p == PF) begin
				oe_n_d[p] = ~dir_q[p];
			end else begin
				oe_n_d[p] = ~dir_q[p] | (~cfg_q[p] & value_q[p]);
			end
		end
	end

	assign status_d = (status_q & ~status_clr) | events;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bus_q <= gpio_ports_misc_control_pkg::BUS_IDLE;
			waitrequest_q <= 1'b1;
			readdata_q <= 32'h0000_0000;
		end else begin
			case (bus_q)
				gpio_ports_misc_control_pkg::BUS_IDLE: begin
					if (req) begin
						bus_q <= gpio_ports_misc_control_pkg::BUS_DONE;
						waitrequest_q <= 1'b0;
						readdata_q <= {24'h00_0000, rd_byte};
					end
				end
				gpio_ports_misc_control_pkg::BUS_DONE: begin
					bus_q <= gpio_ports_misc_control_pkg::BUS_IDLE;
					waitrequest_q <= 1'b1;
				end
				default: begin
					bus_q <= gpio_ports_misc_control_pkg::BUS_IDLE;
					waitrequest_q <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			value_q <= '0;
			dir_q <= '0;
			cfg_q <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (wr_fire && sel.port == 3'(p)) begin
					if (is_value) begin
						value_q[p] <= wdata;
					end
					if (is_dir) begin
						dir_q[p] <= wdata;
					end
					if (is_cfg && p != PB && p != PF) begin
						cfg_q[p] <= wdata;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			misc_q <= `MISC_RESET;
			status_q <= 2'h0;
			mask_q <= 2'h0;
			irq_q <= 1'b0;
		end else begin
			if (wr_misc) begin
				misc_q <= misc_d;
			end
			status_q <= status_d;
			if (wr_mask) begin
				mask_q <= wdata[1:0];
			end
			irq_q <= |(status_q & mask_q);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pin_out_q <= '0;
			pin_oe_n_q <= '1;
			cpu_div_q <= 8'h04;
			coproc_div_q <= 8'h01;
		end else begin
			pin_out_q <= value_q;
			pin_oe_n_q <= oe_n_d;
			cpu_div_q <= div_of(usb_mode, misc_q[`MISC_DIV_EN],
				misc_q[`MISC_DIV_SEL_HI:`MISC_DIV_SEL_LO]);
			coproc_div_q <= 8'h01;
		end
	end

	assign av_readdata = readdata_q;
	assign av_waitrequest = waitrequest_q;
	assign pin_out = pin_out_q;
	assign pin_oe_n = pin_oe_n_q;
	assign clk_pin_out_enable = misc_q[`MISC_CLK_PIN_OUT];
	assign cpu_clk_div = cpu_div_q;
	assign coproc_clk_div = coproc_div_q;
	assign irq = irq_q;

	property p_value_store;
		@(posedge sys_clk) disable iff (!rstn)
		(wr_fire && is_value && sel.port == 3'(PB)) |=> value_q[PB] == $past(wdata);
	endproperty
	a_value_store: assert property (p_value_store) else $error("value write lost");

	property p_read_input;
		@(posedge sys_clk) disable iff (!rstn)
		(bus_q == gpio_ports_misc_control_pkg::BUS_IDLE && av_req.read && sel.hit && is_value
			&& sel.port == 3'(PA) && dir_q[PA] == 8'h00) |=> readdata_q[7:0] == $past(sync2_q[PA]);
	endproperty
	a_read_input: assert property (p_read_input) else $error("input read not pin level");

	property p_dir_pushpull;
		@(posedge sys_clk) disable iff (!rstn)
		##1 pin_oe_n_q[PB] == ~$past(dir_q[PB]) && pin_out_q[PB] == $past(value_q[PB]);
	endproperty
	a_dir_pushpull: assert property (p_dir_pushpull) else $error("port b drive wrong");

	property p_open_drain;
		@(posedge sys_clk) disable iff (!rstn)
		(dir_q[PD][0] && !cfg_q[PD][0] && value_q[PD][0]) |=> pin_oe_n_q[PD][0];
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drives high");

	property p_sens_guard;
		@(posedge sys_clk) disable iff (!rstn)
		(wr_misc && !mask_level3) |=> $stable(misc_q[7:6]) && $stable(misc_q[4:3]);
	endproperty
	a_sens_guard: assert property (p_sens_guard) else $error("sensitivity changed unmasked");

	property p_fall_a;
		@(posedge sys_clk) disable iff (!rstn)
		(misc_q[7:6] == `SENS_FALL && |(fall_a & en_a)) |=> status_q[`IRQ_BIT_GROUP_A];
	endproperty
	a_fall_a: assert property (p_fall_a) else $error("group a falling edge missed");

	property p_rise_d;
		@(posedge sys_clk) disable iff (!rstn)
		(misc_q[4:3] == `SENS_RISE && |(fall_d & en_d) && !(|(rise_d & en_d)) && !status_q[1]
			&& !wr_status) |=> !status_q[`IRQ_BIT_GROUP_D];
	endproperty
	a_rise_d: assert property (p_rise_d) else $error("group d fired on falling edge");

	property p_div_default;
		@(posedge sys_clk) disable iff (!rstn)
		(!misc_q[0] && !usb_mode) |=> cpu_div_q == 8'h04;
	endproperty
	a_div_default: assert property (p_div_default) else $error("default divide wrong");

	property p_coproc;
		@(posedge sys_clk) disable iff (!rstn)
		$changed(cpu_div_q) |-> coproc_div_q == 8'h01;
	endproperty
	a_coproc: assert property (p_coproc) else $error("coprocessor clock moved");

	property p_irq_out;
		@(posedge sys_clk) disable iff (!rstn)
		(status_q[0] && mask_q[0]) [*2] |-> irq_q;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

	property p_status_sticky;
		@(posedge sys_clk) disable iff (!rstn)
		(status_q[`IRQ_BIT_GROUP_A] && !(wr_status && wdata[`IRQ_BIT_GROUP_A]))
			|=> status_q[`IRQ_BIT_GROUP_A];
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

	property p_clk_pin;
		@(posedge sys_clk) disable iff (!rstn)
		wr_misc |=> clk_pin_out_enable == $past(wdata[`MISC_CLK_PIN_OUT]);
	endproperty
	a_clk_pin: assert property (p_clk_pin) else $error("clock pin enable not stored");

	property p_dir_store;
		@(posedge sys_clk) disable iff (!rstn)
		(wr_fire && is_dir && sel.port == 3'(PD)) |=> dir_q[PD] == $past(wdata);
	endproperty
	a_dir_store: assert property (p_dir_store) else $error("direction write lost");

	property p_wait_one;
		@(posedge sys_clk) disable iff (!rstn)
		!waitrequest_q |=> waitrequest_q;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");

	property p_irq_quiet;
		@(posedge sys_clk) disable iff (!rstn)
		!(|(status_q & mask_q)) |=> !irq_q;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without cause");

	c_write: cover property (@(posedge sys_clk) disable iff (!rstn) wr_fire && is_value);
	c_irq: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(irq_q));
	c_div: cover property (@(posedge sys_clk) disable iff (!rstn) $changed(cpu_div_q));
	c_sens_refused: cover property (@(posedge sys_clk) disable iff (!rstn) wr_misc && !mask_level3);
endmodule

/* File: src/gpio_ports_misc_control_regs.svh */
// register indices, field positions, reset values and clock figures
`ifndef GPIO_PORTS_MISC_CONTROL_REGS_SVH
`define GPIO_PORTS_MISC_CONTROL_REGS_SVH
`define IDX_PORT_A_VALUE 6'h00
`define IDX_PORT_A_DIRECTION 6'h01
`define IDX_PORT_A_PAD_CONFIG 6'h02
`define IDX_PORT_B_VALUE 6'h03
`define IDX_PORT_B_DIRECTION 6'h04
`define IDX_UNUSED 6'h05
`define IDX_PORT_C_VALUE 6'h06
`define IDX_PORT_C_DIRECTION 6'h07
`define IDX_PORT_C_PAD_CONFIG 6'h08
`define IDX_PORT_D_VALUE 6'h09
`define IDX_PORT_D_DIRECTION 6'h0a
`define IDX_PORT_D_PAD_CONFIG 6'h0b
`define IDX_PORT_E_VALUE 6'h0c
`define IDX_PORT_E_DIRECTION 6'h0d
`define IDX_PORT_E_PAD_CONFIG 6'h0e
`define IDX_PORT_F_VALUE 6'h0f
`define IDX_PORT_F_DIRECTION 6'h10
`define IDX_MISC_CONTROL_ONE 6'h11
`define IDX_IRQ_STATUS 6'h12
`define IDX_IRQ_MASK 6'h13
`define PORT_RESET 8'h00
`define MISC_RESET 8'h00
`define MISC_EDGE_SEL_A_HI 7
`define MISC_EDGE_SEL_A_LO 6
`define MISC_CLK_PIN_OUT 5
`define MISC_EDGE_SEL_D_HI 4
`define MISC_EDGE_SEL_D_LO 3
`define MISC_DIV_SEL_HI 2
`define MISC_DIV_SEL_LO 1
`define MISC_DIV_EN 0
`define SENS_FALL_LOW 2'h0
`define SENS_RISE 2'h1
`define SENS_FALL 2'h2
`define SENS_BOTH 2'h3
`define IRQ_BIT_GROUP_A 0
`define IRQ_BIT_GROUP_D 1
`define OSC_KHZ 16'h2ee0
`define PLL_KHZ 16'hbb80
`define OSC_DEFAULT_KHZ 16'h0bb8
`define PLL_DEFAULT_KHZ 16'h1770
`define OSC_SEL0_KHZ 16'h1770
`define OSC_SEL1_KHZ 16'h02ee
`define OSC_SEL2_KHZ 16'h05dc
`define OSC_SEL3_KHZ 16'h0177
`define PLL_SEL0_KHZ 16'h1f40
`define PLL_SEL1_KHZ 16'h03e8
`define PLL_SEL2_KHZ 16'h07d0
`define PLL_SEL3_KHZ 16'h00fa
`endif

/* File: src/gpio_ports_misc_control_pkg.sv */
// types for the port and miscellaneous control block
package gpio_ports_misc_control_pkg;
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} avalon_req_t;
	typedef struct packed {
		logic hit;
		logic [1:0] kind;
		logic [2:0] port;
	} reg_sel_t;
	typedef enum logic [1:0] {KIND_VALUE, KIND_DIR, KIND_CFG, KIND_MISC} reg_kind_t;
	typedef enum {BUS_IDLE, BUS_DONE} bus_state_t;
endpackage

/* File: test/gpio_pin_partner.sv */
// board side of the pins: driven pins read back, released pins follow the board
`timescale 1ns/1ps
module gpio_pin_partner (
	input wire logic [5:0][7:0] pin_out,
	input wire logic [5:0][7:0] pin_oe_n,
	input wire logic [5:0][7:0] ext_level,
	output logic [5:0][7:0] pin_in
);
	// released or open-drain high pins take the board level
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

/* File: test/gpio_ports_misc_control_tb.sv */
// self-checking bench for the gpio ports and misc control block
`timescale 1ns/1ps
module gpio_ports_misc_control_tb;
	logic sys_clk;
	logic rstn;
	gpio_ports_misc_control_pkg::avalon_req_t av_req;
	logic [31:0] av_readdata;
	logic av_waitrequest;
	logic [5:0][7:0] pin_in;
	logic [5:0][7:0] pin_out;
	logic [5:0][7:0] pin_oe_n;
	logic [5:0][7:0] ext_level;
	logic irq_mask_hi;
	logic irq_mask_lo;
	logic usb_mode;
	logic clk_pin_out_enable;
	logic [7:0] cpu_clk_div;
	logic [7:0] coproc_clk_div;
	logic irq;
	int error_cnt;
	int checked;
	int cyc;

	gpio_ports_misc_control u_gpio_ports_misc_control (
		.sys_clk(sys_clk), .rstn(rstn), .av_req(av_req), .av_readdata(av_readdata),
		.av_waitrequest(av_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .irq_mask_hi(irq_mask_hi), .irq_mask_lo(irq_mask_lo),
		.usb_mode(usb_mode), .clk_pin_out_enable(clk_pin_out_enable),
		.cpu_clk_div(cpu_clk_div), .coproc_clk_div(coproc_clk_div), .irq(irq)
	);
	gpio_pin_partner u_gpio_pin_partner (
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .pin_in(pin_in)
	);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic stop_test();
		if (error_cnt == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 8000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// one transfer, held until waitrequest is sampled low
	task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] wd,
			output logic [7:0] rd_d);
		av_req.read <= ~we;
		av_req.write <= we;
		av_req.address <= {idx, 2'b00};
		av_req.byteenable <= 4'hf;
		av_req.writedata <= {24'h00_0000, wd};
		do begin
			@(posedge sys_clk);
		end while (av_waitrequest !== 1'b0);
		rd_d = av_readdata[7:0];
		av_req.read <= 1'b0;
		av_req.write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
		logic [7:0] d;
		bus(1'b1, idx, wd, d);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		bus(1'b0, idx, 8'h00, d);
		check("readdata", d, exp);
	endtask

	task automatic t_reset();
		for (int i = 0; i < 21; i++) begin
			rd(i[5:0], 8'h00);
		end
		check("oe_n_f", pin_oe_n[5], 8'hff);
		check("oe_n_a", pin_oe_n[0], 8'hff);
		check("cpu_div", cpu_clk_div, 8'h04);
		check("clk_out", {7'h00, clk_pin_out_enable}, 8'h00);
	endtask

	task automatic t_latch();
		ext_level[0] <= 8'hc3;
		wr(6'h00, 8'h5a);
		idle(4);
		rd(6'h00, 8'hc3);
		wr(6'h02, 8'hff);
		wr(6'h01, 8'hff);
		idle(3);
		check("out_a", pin_out[0], 8'h5a);
		check("oe_n_a", pin_oe_n[0], 8'h00);
		wr(6'h01, 8'h0f);
		idle(3);
		check("oe_n_a", pin_oe_n[0], 8'hf0);
	endtask

	task automatic t_drive_mode();
		wr(6'h0b, 8'h00);
		wr(6'h09, 8'h0f);
		wr(6'h0a, 8'hff);
		idle(3);
		check("oe_n_d", pin_oe_n[3], 8'h0f);
		wr(6'h0b, 8'hff);
		idle(3);
		check("oe_n_d", pin_oe_n[3], 8'h00);
		wr(6'h05, 8'haa);
		rd(6'h05, 8'h00);
		wr(6'h03, 8'hff);
		wr(6'h04, 8'hf0);
		wr(6'h10, 8'h3c);
		wr(6'h0f, 8'h81);
		idle(3);
		check("oe_n_b", pin_oe_n[1], 8'h0f);
		check("oe_n_f", pin_oe_n[5], 8'hc3);
		check("out_f", pin_out[5], 8'h81);
	endtask

	task automatic t_irq();
		irq_mask_hi <= 1'b1;
		irq_mask_lo <= 1'b1;
		ext_level[0][0] <= 1'b1;
		ext_level[3][0] <= 1'b0;
		wr(6'h01, 8'h00);
		wr(6'h02, 8'h01);
		wr(6'h0a, 8'h00);
		wr(6'h0b, 8'h01);
		wr(6'h11, 8'h88);
		wr(6'h13, 8'h03);
		idle(4);
		wr(6'h12, 8'h03);
		rd(6'h12, 8'h00);
		ext_level[0][0] <= 1'b0;
		idle(6);
		rd(6'h12, 8'h01);
		check("irq", {7'h00, irq}, 8'h01);
		wr(6'h12, 8'h01);
		idle(3);
		rd(6'h12, 8'h00);
		check("irq", {7'h00, irq}, 8'h00);
		ext_level[3][0] <= 1'b1;
		idle(6);
		rd(6'h12, 8'h02);
		wr(6'h12, 8'h02);
		wr(6'h13, 8'h00);
		ext_level[0][0] <= 1'b1;
		ext_level[3][0] <= 1'b0;
		idle(4);
		ext_level[0][0] <= 1'b0;
		idle(6);
		rd(6'h12, 8'h01);
		check("irq", {7'h00, irq}, 8'h00);
		wr(6'h13, 8'h01);
		idle(3);
		check("irq", {7'h00, irq}, 8'h01);
		wr(6'h11, 8'h08);
		wr(6'h12, 8'h01);
		idle(5);
		rd(6'h12, 8'h01);
		irq_mask_hi <= 1'b0;
		wr(6'h11, 8'hd0);
		rd(6'h11, 8'h08);
		irq_mask_hi <= 1'b1;
		wr(6'h11, 8'hd0);
		rd(6'h11, 8'hd0);
		wr(6'h13, 8'h00);
	endtask

	task automatic t_clock();
		logic [7:0] osc_div [4];
		logic [7:0] pll_div [4];
		osc_div = '{8'h02, 8'h10, 8'h08, 8'h20};
		pll_div = '{8'h06, 8'h30, 8'h18, 8'hc0};
		for (int u = 0; u < 2; u++) begin
			usb_mode <= u[0];
			for (int s = 0; s < 4; s++) begin
				wr(6'h11, {2'b00, 1'b1, 2'b00, s[1:0], 1'b1});
				idle(2);
				check("cpu_div", cpu_clk_div, u ? pll_div[s] : osc_div[s]);
				check("coproc", coproc_clk_div, 8'h01);
				check("clk_out", {7'h00, clk_pin_out_enable}, 8'h01);
			end
			wr(6'h11, 8'h06);
			idle(2);
			check("cpu_div", cpu_clk_div, u ? 8'h08 : 8'h04);
			check("clk_out", {7'h00, clk_pin_out_enable}, 8'h00);
		end
	endtask

	initial begin
		rstn = 1'b0;
		av_req = '0;
		ext_level = '0;
		irq_mask_hi = 1'b0;
		irq_mask_lo = 1'b0;
		usb_mode = 1'b0;
		error_cnt = 0;
		checked = 0;
		cyc = 0;
		idle(4);
		rstn <= 1'b1;
		idle(1);
		t_reset();
		t_latch();
		t_drive_mode();
		t_irq();
		t_clock();
		stop_test();
	end
endmodule
